/* bench/lble_prog_model.sv */
`timescale 1ns/10ps
`default_nettype none
// program memory model: answers one cycle after a read strobe
module lble_prog_model
  import lble_pkg::*;
#(
  parameter int DEPTH = 64,  // words held
  parameter int AW    = 12   // address width
) (
  input  wire logic              sys_clk_in,    // system clock
  input  wire logic              prog_rd_in,    // read strobe
  input  wire logic [AW-1:0]     prog_addr_in,  // word address
  output logic      [WORD_W-1:0] prog_data_out  // word, one cycle later
);
  logic [WORD_W-1:0] mem [DEPTH];  // program words, loaded by the bench

  initial prog_data_out = 16'h5a5a;  // arbitrary start value

  // a read lands next cycle; otherwise every bit flips so stale words never pass
  always @(posedge sys_clk_in) begin
    if (prog_rd_in && prog_addr_in < AW'(DEPTH)) begin
      prog_data_out <= mem[prog_addr_in];
    end else begin
      prog_data_out <= ~prog_data_out;
    end
  end
endmodule : lble_prog_model
`default_nettype wire

/* bench/tb_ladder_bit_logic_evaluator.sv */
`timescale 1ns/10ps
`default_nettype none
// self-checking bench for the ladder bit logic evaluator
module tb_ladder_bit_logic_evaluator;
  import lble_pkg::*;
  localparam int CAP = 64;                                   // shortened capacity
  localparam int AW  = 12;                                   // program address width
  localparam logic [BIT_AW-1:0] COIL_A = {AREA_HOLDING, 9'h010};  // coil target
  localparam logic [BIT_AW-1:0] BAD_A  = {AREA_HOLDING, 9'h014};  // never to be written
  logic              sys_clk_in     = 1'b0;  // clock
  logic              sys_rst_in     = 1'b1;  // reset
  logic [WORD_W-1:0] prog_data;             // word from model
  logic [AW-1:0]     prog_addr_out;         // word address
  logic              prog_rd_out;           // read strobe
  logic              ext_wr_en_in   = 1'b0; // bit write strobe
  logic [BIT_AW-1:0] ext_wr_addr_in = '0;   // bit write address
  logic              ext_wr_bit_in  = 1'b0; // bit write value
  logic              exec_cond_out;         // execution condition
  logic [AW-1:0]     step_addr_out;         // instruction address
  logic              running_out;           // program running
  logic              no_end_out;            // halted, no end
  logic              pass_end_out;          // end of pass pulse
  logic              coil_wr_out;           // coil pulse
  logic [BIT_AW-1:0] coil_addr_out;         // coil address
  logic              coil_bit_out;          // coil value
  logic              area_fault_out;        // area fault pulse
  logic              stack_fault_out;       // stack fault pulse
  int                n_fail = 0;            // mismatches
  int                checks = 0;            // comparisons
  int                ptr;                   // program load pointer
  logic              bad_hit, coil_seen, sf_seen, af_seen;  // sticky monitors

  always #2 sys_clk_in = ~sys_clk_in;

  lble_evaluator #(.PROG_CAP(CAP), .PAW(AW)) DUT (
    .sys_clk_in(sys_clk_in), .sys_rst_in(sys_rst_in), .prog_data_in(prog_data),
    .prog_addr_out(prog_addr_out), .prog_rd_out(prog_rd_out),
    .ext_wr_en_in(ext_wr_en_in), .ext_wr_addr_in(ext_wr_addr_in),
    .ext_wr_bit_in(ext_wr_bit_in), .exec_cond_out(exec_cond_out),
    .step_addr_out(step_addr_out),
    .running_out(running_out), .no_end_out(no_end_out), .pass_end_out(pass_end_out),
    .coil_wr_out(coil_wr_out), .coil_addr_out(coil_addr_out), .coil_bit_out(coil_bit_out),
    .area_fault_out(area_fault_out), .stack_fault_out(stack_fault_out));

  lble_prog_model #(.DEPTH(CAP), .AW(AW)) PMEM (
    .sys_clk_in(sys_clk_in), .prog_rd_in(prog_rd_out),
    .prog_addr_in(prog_addr_out), .prog_data_out(prog_data));

  // sticky flags for pulses that come and go between checks
  always @(negedge sys_clk_in) begin
    if (coil_wr_out === 1'b1) coil_seen = 1'b1;
    if (coil_wr_out === 1'b1 && coil_addr_out === BAD_A) bad_hit = 1'b1;
    if (stack_fault_out === 1'b1) sf_seen = 1'b1;
    if (area_fault_out === 1'b1) af_seen = 1'b1;
  end

  // compare and count
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  // verdict and end of run
  task automatic summarize();
    if (n_fail == 0 && checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : summarize

  function automatic logic [15:0] w(lble_op_t op, lble_area_t ar, logic [8:0] ofs);
    return {op, ar, ofs};
  endfunction : w

  // expected one-word condition result
  function automatic logic ev(lble_op_t op, logic c, logic b);
    case (op)
      OP_SER:     return c & b;
      OP_SER_INV: return c & ~b;
      OP_PAR:     return c | b;
      default:    return c | ~b;
    endcase
  endfunction : ev

  // empty the program (all no-ops, no end)
  task automatic clr();
    for (int i = 0; i < CAP; i++) PMEM.mem[i] = 16'h0000;
    ptr = 0;
  endtask : clr

  task automatic put(input logic [15:0] word);
    PMEM.mem[ptr] = word;
    ptr++;
  endtask : put

  // reset for five cycles, check the reset state
  task automatic reset_dut();
    @(negedge sys_clk_in);
    sys_rst_in = 1'b1;
    repeat (5) @(negedge sys_clk_in);
    {bad_hit, coil_seen, sf_seen, af_seen} = 4'h0;
    check(16'(prog_addr_out), 16'h0000);
    check(16'(exec_cond_out), 16'h0000);
    sys_rst_in = 1'b0;
  endtask : reset_dut

  task automatic wait_pass(input int n);
    int c;
    c = 0;
    for (int k = 0; k < 3000 && c < n; k++) begin
      @(negedge sys_clk_in);
      if (pass_end_out === 1'b1) c++;
    end
    check(16'(c), 16'(n));
  endtask : wait_pass

  // reset, write internal bits 0..7 and temp bit 0, let two passes run
  task automatic run(input logic [8:0] b);
    reset_dut();
    for (int i = 0; i < 9; i++) begin
      @(negedge sys_clk_in);
      ext_wr_en_in   = 1'b1;
      ext_wr_addr_in = (i < 8) ? {AREA_INTERNAL, 9'(i)} : {AREA_TEMP, 9'h000};
      ext_wr_bit_in  = b[i];
    end
    @(negedge sys_clk_in);
    ext_wr_en_in = 1'b0;
    wait_pass(2);
  endtask : run

  // every begin, condition and coil kind over all operand values
  task automatic s_basic();
    lble_op_t bg, op, cl;
    for (int i = 0; i < 64; i++) begin
      bg = i[0] ? OP_BEGIN_INV : OP_BEGIN;
      op = OP_SER + lble_op_t'(i[2:1]);
      cl = i[3] ? OP_COIL_INV : OP_COIL;
      clr();
      put(w(bg, AREA_INTERNAL, 9'h000));
      put(w(op, AREA_INTERNAL, 9'h001));
      put(w(cl, AREA_HOLDING, 9'h010));
      put(w(OP_END, 3'h0, 9'h000));
      run({7'h00, i[5], i[4]});
      check(16'(coil_bit_out),
            16'(ev(op, i[0] ^ i[4], i[5]) ^ i[3]));
      check(16'(exec_cond_out), 16'(ev(op, i[0] ^ i[4], i[5])));
      check(16'(coil_addr_out), 16'(COIL_A));
    end
  endtask : s_basic

  // mixed chain evaluated left to right
  task automatic s_order();
    for (int i = 0; i < 32; i++) begin
      clr();
      put(w(OP_BEGIN, AREA_INTERNAL, 9'h000));
      put(w(OP_SER, AREA_INTERNAL, 9'h001));
      put(w(OP_PAR, AREA_INTERNAL, 9'h002));
      put(w(OP_SER, AREA_INTERNAL, 9'h003));
      put(w(OP_SER_INV, AREA_INTERNAL, 9'h004));
      put(w(OP_COIL, AREA_HOLDING, 9'h010));
      put(w(OP_END, 3'h0, 9'h000));
      run({4'h0, i[4:0]});
      check(16'(coil_bit_out), 16'((((i[0] & i[1]) | i[2]) & i[3]) & ~i[4]));
    end
  endtask : s_order

  // two blocks joined by series or parallel merge
  task automatic s_merge();
    logic l, r;
    for (int i = 0; i < 32; i++) begin
      clr();
      put(w(OP_BEGIN, AREA_INTERNAL, 9'h000));
      put(w(OP_PAR, AREA_INTERNAL, 9'h001));
      put(w(OP_BEGIN, AREA_INTERNAL, 9'h002));
      put(w(OP_PAR_INV, AREA_INTERNAL, 9'h003));
      put(w(i[4] ? OP_PAR_MERGE : OP_SER_MERGE, 3'h0, 9'h000));
      put(w(OP_COIL, AREA_HOLDING, 9'h010));
      put(w(OP_END, 3'h0, 9'h000));
      run({5'h00, i[3:0]});
      l = i[0] | i[1];
      r = i[2] | ~i[3];
      check(16'(coil_bit_out), 16'(i[4] ? (l | r) : (l & r)));
    end
  endtask : s_merge

  // eight blocks with seven deferred merges, then one block too many
  task automatic s_deep();
    for (int i = 0; i < 3; i++) begin
      clr();
      for (int k = 0; k < 8; k++) put(w(OP_BEGIN, AREA_INTERNAL, 9'(k)));
      if (i == 2) put(w(OP_BEGIN, AREA_INTERNAL, 9'h000));
      for (int k = 0; k < 7; k++) put(w(OP_SER_MERGE, 3'h0, 9'h000));
      put(w(OP_COIL, AREA_HOLDING, 9'h010));
      put(w(OP_END, 3'h0, 9'h000));
      run(i == 1 ? 9'h0fe : 9'h0ff);
      if (i < 2) check(16'(coil_bit_out), 16'(i == 0));
      check(16'(sf_seen), 16'(i == 2));
    end
  endtask : s_deep

  // temp area use, multi-word skip, end handling, missing end
  task automatic s_misc();
    clr();
    put(w(OP_BEGIN, AREA_INTERNAL, 9'h000));
    put(w(OP_SER, AREA_TEMP, 9'h000));
    put(w(OP_COIL, AREA_HOLDING, 9'h010));
    put(w(OP_END, 3'h0, 9'h000));
    run(9'h001);
    check(16'(coil_bit_out), 16'h0001);
    check(16'(af_seen), 16'h0001);
    clr();
    put(w(OP_BEGIN, AREA_TEMP, 9'h000));
    put(w(OP_COIL, AREA_HOLDING, 9'h010));
    put(w(OP_END, 3'h0, 9'h000));
    run(9'h100);
    check(16'(coil_bit_out), 16'h0001);
    check(16'(af_seen), 16'h0000);
    clr();
    put(w(OP_BEGIN, AREA_INTERNAL, 9'h000));
    put(w(OP_MULTI, 3'h0, 9'h003));
    for (int k = 0; k < 3; k++) put(w(OP_COIL, AREA_HOLDING, 9'h014));
    put(w(OP_COIL, AREA_HOLDING, 9'h010));
    put(w(OP_END, 3'h0, 9'h000));
    put(w(OP_BEGIN, AREA_INTERNAL, 9'h001));
    put(w(OP_COIL, AREA_HOLDING, 9'h014));
    put(w(OP_END, 3'h0, 9'h000));
    run(9'h003);
    check(16'(coil_bit_out), 16'h0001);
    check(16'(coil_addr_out), 16'(COIL_A));
    check(16'(bad_hit), 16'h0000);
    check(16'(running_out), 16'h0001);
    clr();
    put(w(OP_BEGIN, AREA_INTERNAL, 9'h000));
    put(w(OP_COIL, AREA_HOLDING, 9'h010));
    put(w(OP_MULTI, 3'h0, 9'h002));
    reset_dut();
    for (int k = 0; k < 1000 && no_end_out !== 1'b1; k++) @(negedge sys_clk_in);
    check(16'(no_end_out), 16'h0001);
    // one three-word record among single words: two records fewer than words
    check(16'(step_addr_out), 16'(CAP - 2));
    check(16'(running_out), 16'h0000);
    check(16'(coil_seen), 16'h0000);
  endtask : s_misc

  // main sequence
  initial begin
    s_basic();
    s_order();
    s_merge();
    s_deep();
    s_misc();
    summarize();
  end

  // hang guard, well beyond the expected run length
  initial begin
    #300000;
    n_fail++;
    summarize();
  end
endmodule : tb_ladder_bit_logic_evaluator
`default_nettype wire

/* rtl/lble_bit_if.sv */
`timescale 1ns/10ps
`default_nettype none
// bit data port between evaluator and bit store
interface lble_bit_if;
  import lble_pkg::*;
  logic              rd_en;       // read strobe, data next cycle
  logic [BIT_AW-1:0] rd_addr;     // read bit address
  logic              rd_bit;      // registered read data
  logic              wr_en;       // coil write strobe
  logic [BIT_AW-1:0] wr_addr;     // coil write address
  logic              wr_bit;      // coil write data
  logic              ext_wr_en;   // outside write of input bits
  logic [BIT_AW-1:0] ext_wr_addr; // outside write address
  logic              ext_wr_bit;  // outside write data
  modport evaluator (output rd_en, rd_addr, wr_en, wr_addr, wr_bit,
                     output ext_wr_en, ext_wr_addr, ext_wr_bit, input rd_bit);
  modport store (input rd_en, rd_addr, wr_en, wr_addr, wr_bit,
                 input ext_wr_en, ext_wr_addr, ext_wr_bit, output rd_bit);
endinterface : lble_bit_if
`default_nettype wire

/* rtl/lble_bit_mem.sv */
`timescale 1ns/10ps
`default_nettype none
// bit store holding every data area, one bit per address
module lble_bit_mem
  import lble_pkg::*;
(
  input  wire logic sys_clk_in,   // system clock
  lble_bit_if.store bus           // evaluator side
);
  logic mem [0:(1<<BIT_AW)-1];    // all bit areas
  logic rd_bit_reg;               // registered read data

  // writes; a coil write wins over an outside write to the same bit
  always_ff @(posedge sys_clk_in) begin
    if (bus.ext_wr_en && !(bus.wr_en && bus.wr_addr == bus.ext_wr_addr)) begin
      mem[bus.ext_wr_addr] <= bus.ext_wr_bit;
    end
    if (bus.wr_en) begin
      mem[bus.wr_addr] <= bus.wr_bit;
    end
  end

  // read, data out of a register one cycle later
  always_ff @(posedge sys_clk_in) begin
    if (bus.rd_en) begin
      rd_bit_reg <= mem[bus.rd_addr];
    end
  end

  assign bus.rd_bit = rd_bit_reg;
endmodule : lble_bit_mem
`default_nettype wire

/* rtl/lble_evaluator.sv */
`timescale 1ns/10ps
`default_nettype none
module lble_evaluator
  import lble_pkg::*;
#(
  parameter int PROG_CAP = PROG_WORDS,               // program capacity in words
  parameter int PAW      = $clog2(PROG_WORDS) + 1    // program address width
) (
  input  wire logic              sys_clk_in,         // system clock, 250 MHz
  input  wire logic              sys_rst_in,         // synchronous reset, high
  input  wire logic [WORD_W-1:0] prog_data_in,       // program word, one cycle after read
  output logic      [PAW-1:0]    prog_addr_out,      // program word address
  output logic                   prog_rd_out,        // program read strobe
  input  wire logic              ext_wr_en_in,       // outside bit write strobe
  input  wire logic [BIT_AW-1:0] ext_wr_addr_in,     // outside bit write address
  input  wire logic              ext_wr_bit_in,      // outside bit write value
  output logic                   exec_cond_out,      // execution condition
  output logic      [PAW-1:0]    step_addr_out,      // current instruction address
  output logic                   running_out,        // program found and running
  output logic                   no_end_out,         // no end instruction, halted
  output logic                   pass_end_out,       // pulse at each end of pass
  output logic                   coil_wr_out,        // pulse, coil bit written
  output logic      [BIT_AW-1:0] coil_addr_out,      // coil bit address
  output logic                   coil_bit_out,       // coil bit value
  output logic                   area_fault_out,     // pulse, illegal operand area
  output logic                   stack_fault_out     // pulse, save buffer misuse
);
  typedef enum logic [4:0] {
    ST_FETCH  = 5'h01,           // issue program read
    ST_WAIT   = 5'h02,           // capture first word
    ST_DECODE = 5'h04,           // decode and advance
    ST_EXEC   = 5'h08,           // combine operand bit
    ST_HALT   = 5'h10            // scan found no end
  } lble_state_e;

  lble_bit_if bit_bus ();        // bit store port

  lble_state_e       state_reg;         // sequencer state
  logic [WORD_W-1:0] instr_reg;         // first word of current record
  logic [PAW-1:0]    word_addr_reg;     // program word address
  logic [PAW-1:0]    step_reg;          // instruction address
  logic              run_reg;           // low while scanning for an end
  logic              halt_reg;          // scan found no end
  logic              cond_reg;          // execution condition
  logic              line_reg;          // a line has begun
  logic [SAVE_DEPTH-1:0] save_reg;      // saved conditions, newest at 0
  logic [3:0]        depth_reg;         // saved count
  logic              pass_reg;          // end of pass pulse
  logic              coil_wr_reg;       // coil write pulse
  logic [BIT_AW-1:0] coil_addr_reg;     // coil address copy
  logic              coil_bit_reg;      // coil value copy
  logic              afault_reg;        // area fault pulse
  logic              sfault_reg;        // stack fault pulse
  lble_op_t          op;                // decoded opcode
  lble_area_t        area;              // decoded area
  logic              is_cond;           // begin, series or parallel
  logic              is_coil;           // coil output
  logic              area_ok;           // operand area legal here
  logic              dec_run;           // decode with effects
  logic [PAW-1:0]    span;              // words in this record

  // condition instruction test
  function automatic logic cond_op(input lble_op_t o);
    return (o >= OP_BEGIN) && (o <= OP_PAR_INV);
  endfunction : cond_op

  // operand as seen by the instruction, inverted forms complement
  function automatic logic eff_bit(input lble_op_t o, input logic b);
    return o[INV_POS] ? !b : b;
  endfunction : eff_bit

  // field decode
  assign op      = instr_reg[OP_HI:OP_LO];
  assign area    = instr_reg[AREA_HI:AREA_LO];
  assign is_cond = cond_op(op);
  assign is_coil = (op == OP_COIL) || (op == OP_COIL_INV);
  // temp bits allowed only for begin and coil
  assign area_ok = (area <= AREA_TIMCNT) ||
                   (area == AREA_TEMP && (op == OP_BEGIN || op == OP_BEGIN_INV || is_coil));
  assign dec_run = (state_reg == ST_DECODE) && run_reg;
  // record length: one word, or one plus extra count for other opcodes
  assign span = (op >= OP_MULTI) ? PAW'(instr_reg[XCNT_HI:0]) + PAW'(1) : PAW'(1);

  // sequencer
  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      state_reg <= ST_FETCH;
    end else begin
      case (state_reg)
        ST_FETCH: state_reg <= (word_addr_reg >= PAW'(PROG_CAP)) ? ST_HALT : ST_WAIT;
        ST_WAIT: state_reg <= ST_DECODE;
        ST_DECODE: state_reg <= (run_reg && is_cond && area_ok) ? ST_EXEC : ST_FETCH;
        ST_EXEC: state_reg <= ST_FETCH;
        ST_HALT: state_reg <= ST_HALT;
        default: state_reg <= ST_FETCH;
      endcase
    end
  end

  // first word capture
  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      instr_reg <= '0;
    end else if (state_reg == ST_WAIT) begin
      instr_reg <= prog_data_in;
    end
  end

  // address walk; end returns to zero
  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      word_addr_reg <= '0;
      step_reg      <= '0;
    end else if (state_reg == ST_DECODE) begin
      if (op == OP_END) begin
        word_addr_reg <= '0;
        step_reg      <= '0;
      end else begin
        word_addr_reg <= word_addr_reg + span;
        step_reg      <= step_reg + PAW'(1);
      end
    end
  end

  // scan for an end before running anything
  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      run_reg  <= 1'b0;
      halt_reg <= 1'b0;
      pass_reg <= 1'b0;
    end else begin
      pass_reg <= dec_run && (op == OP_END);
      if (state_reg == ST_DECODE && op == OP_END) begin
        run_reg <= 1'b1;
      end
      if (state_reg == ST_FETCH && word_addr_reg >= PAW'(PROG_CAP)) begin
        halt_reg <= 1'b1;
      end
    end
  end

  // execution condition and line tracking
  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      cond_reg <= 1'b0;
      line_reg <= 1'b0;
    end else if (state_reg == ST_EXEC) begin
      line_reg <= 1'b1;
      case (op)
        OP_BEGIN, OP_BEGIN_INV: cond_reg <= eff_bit(op, bit_bus.rd_bit);
        OP_SER, OP_SER_INV: cond_reg <= cond_reg & eff_bit(op, bit_bus.rd_bit);
        OP_PAR, OP_PAR_INV: cond_reg <= cond_reg | eff_bit(op, bit_bus.rd_bit);
        default: cond_reg <= cond_reg;
      endcase
    end else if (dec_run) begin
      // merges combine with newest saved condition
      if (op == OP_SER_MERGE && depth_reg != 4'h0) begin
        cond_reg <= cond_reg & save_reg[0];
      end else if (op == OP_PAR_MERGE && depth_reg != 4'h0) begin
        cond_reg <= cond_reg | save_reg[0];
      end
      if (is_coil || op == OP_END) begin
        line_reg <= 1'b0;
      end
    end
  end

  // save buffer: push on mid-line begin, pop on merge
  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      save_reg   <= '0;
      depth_reg  <= 4'h0;
      sfault_reg <= 1'b0;
    end else begin
      sfault_reg <= 1'b0;
      if (state_reg == ST_EXEC && line_reg && (op == OP_BEGIN || op == OP_BEGIN_INV)) begin
        if (depth_reg < 4'(SAVE_DEPTH)) begin
          save_reg  <= {save_reg[SAVE_DEPTH-2:0], cond_reg};
          depth_reg <= depth_reg + 4'h1;
        end else begin
          sfault_reg <= 1'b1;
        end
      end else if (dec_run && (op == OP_SER_MERGE || op == OP_PAR_MERGE)) begin
        if (depth_reg != 4'h0) begin
          save_reg  <= {1'b0, save_reg[SAVE_DEPTH-1:1]};
          depth_reg <= depth_reg - 4'h1;
        end else begin
          sfault_reg <= 1'b1;
        end
      end else if (dec_run && op == OP_END) begin
        depth_reg <= 4'h0;
      end
    end
  end

  // coil and area fault reporting
  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      coil_wr_reg   <= 1'b0;
      coil_addr_reg <= '0;
      coil_bit_reg  <= 1'b0;
      afault_reg    <= 1'b0;
    end else begin
      coil_wr_reg <= bit_bus.wr_en;
      afault_reg  <= dec_run && (is_cond || is_coil) && !area_ok;
      if (bit_bus.wr_en) begin
        coil_addr_reg <= bit_bus.wr_addr;
        coil_bit_reg  <= bit_bus.wr_bit;
      end
    end
  end

  // bit store port
  assign bit_bus.rd_en       = dec_run && is_cond && area_ok;
  assign bit_bus.rd_addr     = instr_reg[AREA_HI:0];
  assign bit_bus.wr_en       = dec_run && is_coil && area_ok;
  assign bit_bus.wr_addr     = instr_reg[AREA_HI:0];
  assign bit_bus.wr_bit      = eff_bit(op, cond_reg);
  assign bit_bus.ext_wr_en   = ext_wr_en_in;
  assign bit_bus.ext_wr_addr = ext_wr_addr_in;
  assign bit_bus.ext_wr_bit  = ext_wr_bit_in;

  lble_bit_mem u_bits (
    .sys_clk_in (sys_clk_in),
    .bus        (bit_bus)
  );

  // outputs
  assign prog_rd_out     = (state_reg == ST_FETCH) && (word_addr_reg < PAW'(PROG_CAP));
  assign prog_addr_out   = word_addr_reg;
  assign step_addr_out   = step_reg;
  assign exec_cond_out   = cond_reg;
  assign running_out     = run_reg;
  assign no_end_out      = halt_reg;
  assign pass_end_out    = pass_reg;
  assign coil_wr_out     = coil_wr_reg;
  assign coil_addr_out   = coil_addr_reg;
  assign coil_bit_out    = coil_bit_reg;
  assign area_fault_out  = afault_reg;
  assign stack_fault_out = sfault_reg;

  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (sys_rst_in);

  a_begin_load: assert property ((state_reg == ST_EXEC && op == OP_BEGIN_INV) |=>
    cond_reg == !$past(bit_bus.rd_bit)) else $error("inverted begin load wrong");
  a_series_plain: assert property ((state_reg == ST_EXEC && op == OP_SER) |=>
    cond_reg == ($past(cond_reg) && $past(bit_bus.rd_bit))) else $error("series wrong");
  a_series_inverted: assert property ((state_reg == ST_EXEC && op == OP_SER_INV) |=>
    cond_reg == ($past(cond_reg) && !$past(bit_bus.rd_bit))) else $error("inv series wrong");
  a_parallel_ops: assert property ((state_reg == ST_EXEC && op[3:1] == 3'h3) |=>
    cond_reg == ($past(cond_reg) || ($past(bit_bus.rd_bit) ^ $past(op[INV_POS]))))
    else $error("parallel wrong");
  a_coil_value: assert property ((dec_run && is_coil && area_ok) |=> coil_wr_reg &&
    coil_bit_reg == ($past(cond_reg) ^ $past(op[INV_POS]))) else $error("coil value wrong");
  a_temp_guard: assert property (bit_bus.rd_en |-> area != AREA_TEMP ||
    op == OP_BEGIN || op == OP_BEGIN_INV) else $error("temp bit read by condition");
  a_one_word: assert property ((dec_run && is_cond) |=>
    word_addr_reg == $past(word_addr_reg) + PAW'(1)) else $error("condition span wrong");
  a_record_span: assert property ((state_reg == ST_DECODE && op != OP_END) |=>
    (word_addr_reg - $past(word_addr_reg)) inside {[1:4]}) else $error("record span wrong");
  a_restart_zero: assert property ((state_reg == ST_DECODE && op == OP_END) |=>
    word_addr_reg == '0 && prog_rd_out) else $error("no restart at zero");
  a_no_end_idle: assert property (halt_reg |->
    !run_reg && !coil_wr_reg && !bit_bus.rd_en) else $error("ran without end");
  a_save_bound: assert property (depth_reg <= 4'(SAVE_DEPTH))
    else $error("save overflow");
  a_push_midline: assert property ((state_reg == ST_EXEC && line_reg && op == OP_BEGIN &&
    depth_reg < 4'(SAVE_DEPTH)) |=> save_reg[0] == $past(cond_reg)) else $error("push lost");
  a_cond_source: assert property ($changed(cond_reg) |->
    $past(state_reg) == ST_EXEC || $past(dec_run)) else $error("condition changed unasked");
  a_start_zero: assert property ($rose(run_reg) |-> word_addr_reg == '0)
    else $error("run not from zero");
  c_series_merge: cover property (dec_run && op == OP_SER_MERGE && depth_reg != 4'h0);
  c_parallel_merge: cover property (dec_run && op == OP_PAR_MERGE && depth_reg != 4'h0);
  c_coil_write: cover property (coil_wr_reg ##[1:40] pass_reg);
  c_halt: cover property ($rose(halt_reg));
endmodule : lble_evaluator
`default_nettype wire

/* rtl/lble_pkg.sv */
`default_nettype none
package lble_pkg;
  // instruction word layout
  localparam int WORD_W    = 16;
  localparam int OP_HI     = 15;                // opcode field top bit
  localparam int OP_LO     = 12;                // opcode field bottom bit
  localparam int AREA_HI   = 11;                // bit area field top bit
  localparam int AREA_LO   = 9;                 // bit area field bottom bit
  localparam int OFS_HI    = 8;                 // bit offset field top bit
  localparam int XCNT_HI   = 1;                 // extra word count, other opcodes
  localparam int BIT_AW    = 12;                // flat bit address: area and offset
  localparam int INV_POS   = 0;                 // opcode bit marking inverted forms

  typedef logic [3:0] lble_op_t;
  typedef logic [2:0] lble_area_t;

  // opcodes; 4'hc..4'hf are other instructions carrying extra words
  localparam lble_op_t OP_NOP   = 4'h0;
  localparam lble_op_t OP_END   = 4'h1;
  localparam lble_op_t OP_BEGIN = 4'h2;         // begin_block_cond
  localparam lble_op_t OP_BEGIN_INV = 4'h3;     // begin_block_inverted
  localparam lble_op_t OP_SER   = 4'h4;
  localparam lble_op_t OP_SER_INV = 4'h5;
  localparam lble_op_t OP_PAR   = 4'h6;
  localparam lble_op_t OP_PAR_INV = 4'h7;
  localparam lble_op_t OP_SER_MERGE = 4'h8;     // block_series_merge
  localparam lble_op_t OP_PAR_MERGE = 4'h9;     // block_parallel_merge
  localparam lble_op_t OP_COIL  = 4'ha;
  localparam lble_op_t OP_COIL_INV = 4'hb;
  localparam lble_op_t OP_MULTI = 4'hc;         // lowest multi-word opcode

  // bit areas
  localparam lble_area_t AREA_INTERNAL = 3'h0;  // internal_bit_area
  localparam lble_area_t AREA_SPECIAL  = 3'h1;  // special_flag_area
  localparam lble_area_t AREA_HOLDING  = 3'h2;  // holding_bit_area
  localparam lble_area_t AREA_AUX      = 3'h3;  // aux_flag_bank
  localparam lble_area_t AREA_LINK     = 3'h4;  // link_bit_area
  localparam lble_area_t AREA_TIMCNT   = 3'h5;  // timer_counter_area
  localparam lble_area_t AREA_TEMP     = 3'h6;  // temp_branch_bits

  localparam int SAVE_DEPTH = 7;                // saved conditions: eight blocks
  localparam int PROG_WORDS = 2048;             // program capacity in words
endpackage : lble_pkg
`default_nettype wire
